// File: hw/rcl_pkg.sv
package rcl_pkg;

  // timing
  localparam int CLK_PERIOD_NS    = 20;
  localparam int EE_SCL_PERIOD_NS = 10000;
  localparam int EE_QTR_CYC       = (EE_SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                    / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] EE_QTR_LAST = 8'(EE_QTR_CYC - 1);

  // four-level pin codes from the level comparators
  localparam logic [1:0] LVL_GND_STRONG = 2'h0;
  localparam logic [1:0] LVL_GND_WEAK   = 2'h1;
  localparam logic [1:0] LVL_FLOAT      = 2'h2;
  localparam logic [1:0] LVL_VDD        = 2'h3;

  // rate modes and generations
  localparam logic [1:0] RATE_G12  = 2'h0;
  localparam logic [1:0] RATE_AUTO = 2'h1;
  localparam logic [1:0] RATE_G3   = 2'h2;
  localparam logic [1:0] RATE_RSVD = 2'h3;
  localparam logic [1:0] GEN2      = 2'h2;
  localparam logic [1:0] GEN3      = 2'h3;

  // serial bus addresses and image layout
  localparam logic [7:0] SLV_ADDR_FIXED = 8'hB0;
  localparam logic [2:0] SLV_ADDR_HI    = 3'h5;
  localparam logic [7:0] EE_DEV_W       = 8'hA0;
  localparam logic [7:0] EE_DEV_R       = 8'hA1;
  localparam logic [7:0] EE_WORD_ADDR   = 8'h00;
  // value is arbitrary: marks a programmed image
  localparam logic [7:0] EE_SIGNATURE   = 8'h5A;
  localparam int         CFG_N          = 4;
  localparam logic [2:0] CFG_LAST       = 3'h4;
  localparam logic [3:0] BITS_BYTE      = 4'h8;

  // configuration byte fields
  localparam int CFG_EQA  = 0;
  localparam int CFG_EQB  = 1;
  localparam int CFG_DEM  = 2;
  localparam int CHAN_A_DEEMPH_STRAP_LSB = 0;
  localparam int CHAN_B_DEEMPH_STRAP_LSB = 2;

  // wishbone word offsets and reset values
  localparam logic [5:0]  WB_STATUS = 6'h00;
  localparam logic [5:0]  WB_MASK   = 6'h01;
  localparam logic [5:0]  WB_STATE  = 6'h02;
  localparam logic [5:0]  WB_CFG    = 6'h03;
  localparam logic [4:0]  MASK_RST  = 5'h00;
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;

  // interrupt bits
  localparam int IRQ_W         = 5;
  localparam int IRQ_LOAD_OK   = 0;
  localparam int IRQ_LOAD_FAIL = 1;
  localparam int IRQ_CABLE     = 2;
  localparam int IRQ_BUS_WR    = 3;
  localparam int IRQ_MODE      = 4;

  typedef enum logic [1:0] {MODE_PIN, MODE_SLAVE, MODE_MASTER} rcl_mode_t;
  typedef enum logic [2:0] {ML_IDLE, ML_START, ML_TX, ML_RX, ML_STOP, ML_DONE, ML_FAIL} rcl_ml_t;
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_AACK, SL_WR, SL_WACK, SL_RD, SL_RACK} rcl_sl_t;

  typedef struct packed {
    logic [1:0]      bus_sel;
    logic [3:0][1:0] ad;
    logic [1:0]      dem_a;
    logic [1:0]      dem_b;
    logic [1:0]      load_lvl;
    logic            cable_absent;
    logic [1:0]      receiver_termination_select;
    logic [1:0]      rate;
    logic [1:0]      gen_det;
    logic            sda;
    logic            scl;
  } rcl_pins_t;

endpackage : rcl_pkg

// File: hw/rcl_sync.sv
`timescale 1ns/1ps
module rcl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  // pins
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic [1:0] stg_reg;
      // first stage feeds only the second
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          stg_reg <= 2'h0;
        end else begin
          stg_reg <= {stg_reg[0], i_async[g]};
        end
      end
      assign o_sync[g] = stg_reg[1];
    end
  endgenerate

endmodule : rcl_sync

// File: hw/rcl_top.sv
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module rcl_top
  import rcl_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_irq,
  // strap and level pins
  input  wire logic [1:0]  i_bus_config_select,
  input  wire logic [7:0]  i_slave_addr_straps,
  input  wire logic [1:0]  i_chan_a_deemph_strap,
  input  wire logic [1:0]  i_chan_b_deemph_strap,
  input  wire logic [1:0]  i_load_start_n,
  input  wire logic        i_cable_absent,
  input  wire logic [1:0]  i_receiver_termination_select,
  input  wire logic [1:0]  i_rate_select,
  input  wire logic [1:0]  i_link_gen_detect,
  // serial bus pins, open drain
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe_n,
  output logic             o_done_n,
  // settings to the analog path
  output logic      [3:0]  o_chan_a_equalize,
  output logic      [3:0]  o_chan_b_equalize,
  output logic      [1:0]  o_chan_a_deemph,
  output logic      [1:0]  o_chan_b_deemph,
  output logic             o_low_power,
  output logic      [1:0]  o_rate_mode,
  output logic             o_term_low_ohm,
  output logic      [1:0]  o_link_gen,
  output logic      [1:0]  o_signal_detect_threshold,
  output logic      [1:0]  o_mode
);

  typedef struct packed {
    logic                       wb_ack;
    logic [31:0]                wb_dat;
    logic [IRQ_W-1:0]           status;
    logic [IRQ_W-1:0]           mask;
    logic                       irq;
    logic [CFG_N-1:0][7:0]      cfg;
    rcl_mode_t                  mode;
    logic                       cable_d;
    rcl_ml_t                    ml;
    logic [7:0]                 qcnt;
    logic [1:0]                 q;
    logic [3:0]                 bitn;
    logic [1:0]                 seq;
    logic [7:0]                 sh_m;
    logic [2:0]                 rxn;
    logic                       sig_ok;
    rcl_sl_t                    sl;
    logic [3:0]                 scnt;
    logic [7:0]                 sh_s;
    logic                       rw;
    logic                       first;
    logic                       nack;
    logic [1:0]                 ptr;
    logic                       scl_d;
    logic                       sda_d;
    logic                       od_lvl;
    logic                       sda_oe_n;
    logic                       scl_oe_n;
    logic                       done_n;
    logic [3:0]                 eq_a;
    logic [3:0]                 eq_b;
    logic [1:0]                 dem_a;
    logic [1:0]                 dem_b;
    logic                       low_power;
    logic [1:0]                 rate;
    logic                       term_low;
    logic [1:0]                 gen;
    logic [1:0]                 signal_detect_threshold;
  } rcl_state_t;

  rcl_state_t s_reg;
  rcl_state_t s_next;
  rcl_pins_t  pins;
  logic [7:0] slv_addr;
  logic       load_low;
  logic       s_en;
  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;
  logic       qtick;
  logic       m_act;

  rcl_sync #(
    .W ($bits(rcl_pins_t))
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_bus_config_select, i_slave_addr_straps, i_chan_a_deemph_strap,
               i_chan_b_deemph_strap, i_load_start_n, i_cable_absent,
               i_receiver_termination_select, i_rate_select, i_link_gen_detect,
               i_sda, i_scl}),
    .o_sync  (pins)
  );

  always_comb begin
    s_next   = s_reg;
    // shared pin reads as load start whenever a bus mode is active
    load_low = ~pins.load_lvl[1];
    // address straps only with load start low
    // straps give the address in both bus modes
    slv_addr = load_low ? {SLV_ADDR_HI, pins.ad[3][1], pins.ad[2][1], pins.ad[1][1],
                           pins.ad[0][1], 1'h0} : SLV_ADDR_FIXED;
    m_act    = (s_reg.ml != ML_IDLE) && (s_reg.ml != ML_DONE) && (s_reg.ml != ML_FAIL);
    // no bus access while loading or after a failed load
    // in master mode the slave answers only after a passed load
    s_en     = (s_reg.mode == MODE_SLAVE) || ((s_reg.mode == MODE_MASTER) && (s_reg.ml == ML_DONE));
    rise     = pins.scl & ~s_reg.scl_d;
    fall     = ~pins.scl & s_reg.scl_d;
    start_c  = pins.scl & s_reg.scl_d & s_reg.sda_d & ~pins.sda;
    stop_c   = pins.scl & s_reg.scl_d & ~s_reg.sda_d & pins.sda;
    qtick    = (s_reg.qcnt == 8'h00);
    s_next.scl_d  = pins.scl;
    s_next.sda_d  = pins.sda;
    s_next.wb_ack = 1'h0;
    s_next.od_lvl = 1'h0;

    unique case (pins.bus_sel)
      LVL_VDD:                      s_next.mode = MODE_SLAVE;
      LVL_FLOAT:                    s_next.mode = MODE_MASTER;
      LVL_GND_STRONG, LVL_GND_WEAK: s_next.mode = MODE_PIN;
    endcase

    // wishbone: one-cycle answer, status cleared on read before new events land
    if (i_wb_cyc && i_wb_stb && !s_reg.wb_ack) begin
      s_next.wb_ack = 1'h1;
      s_next.wb_dat = 32'h0000_0000;
      unique case (i_wb_adr[7:2])
        WB_STATUS: begin
          s_next.wb_dat = {27'h0, s_reg.status};
          if (!i_wb_we) begin
            s_next.status = '0;
          end
        end
        WB_MASK: begin
          s_next.wb_dat = {27'h0, s_reg.mask};
          if (i_wb_we && i_wb_sel[0]) begin
            s_next.mask = i_wb_dat[IRQ_W-1:0];
          end
        end
        WB_STATE: begin
          s_next.wb_dat = {8'h00, slv_addr, 6'h00, s_reg.gen, s_reg.term_low, s_reg.rate,
                           s_reg.low_power, s_reg.ml == ML_FAIL, s_reg.done_n, s_reg.mode};
        end
        WB_CFG: begin
          s_next.wb_dat = s_reg.cfg;
          for (int b = 0; b < CFG_N; b++) begin
            if (i_wb_we && i_wb_sel[b]) begin
              s_next.cfg[b] = i_wb_dat[8*b +: 8];
            end
          end
        end
        default: s_next.wb_dat = 32'h0000_0000;
      endcase
    end

    // EEPROM loader, four quarters per clock bit
    if (m_act) begin
      s_next.qcnt = qtick ? EE_QTR_LAST : 8'(s_reg.qcnt - 8'h01);
    end
    if (s_reg.ml == ML_IDLE) begin
      // load starts on a low load start in master mode
      // a strap held low starts it straight after power-up
      if ((s_reg.mode == MODE_MASTER) && load_low) begin
        s_next.ml   = ML_START;
        s_next.q    = 2'h0;
        s_next.seq  = 2'h0;
        s_next.qcnt = EE_QTR_LAST;
      end
    end else if (m_act && qtick) begin
      s_next.q = 2'(s_reg.q + 2'h1);
      unique case (s_reg.ml)
        ML_START: begin
          unique case (s_reg.q)
            2'h0: s_next.sda_oe_n = 1'h1;
            2'h1: s_next.scl_oe_n = 1'h1;
            2'h2: s_next.sda_oe_n = 1'h0;
            2'h3: begin
              s_next.scl_oe_n = 1'h0;
              s_next.ml       = ML_TX;
              s_next.bitn     = 4'h0;
              s_next.sh_m     = (s_reg.seq == 2'h0) ? EE_DEV_W : EE_DEV_R;
            end
          endcase
        end
        ML_TX: begin
          unique case (s_reg.q)
            2'h0: s_next.sda_oe_n = (s_reg.bitn == BITS_BYTE) ? 1'h1 : s_reg.sh_m[7];
            2'h1: s_next.scl_oe_n = 1'h1;
            2'h2: begin
              // no acknowledge from the memory counts as a failed load
              if ((s_reg.bitn == BITS_BYTE) && pins.sda) begin
                s_next.ml = ML_FAIL;
              end
            end
            2'h3: begin
              s_next.scl_oe_n = 1'h0;
              if (s_reg.bitn != BITS_BYTE) begin
                s_next.sh_m = {s_reg.sh_m[6:0], 1'h0};
                s_next.bitn = 4'(s_reg.bitn + 4'h1);
              end else if (s_reg.seq == 2'h0) begin
                s_next.sh_m = EE_WORD_ADDR;
                s_next.seq  = 2'h1;
                s_next.bitn = 4'h0;
              end else if (s_reg.seq == 2'h1) begin
                s_next.seq = 2'h2;
                s_next.ml  = ML_START;
              end else begin
                s_next.ml   = ML_RX;
                s_next.bitn = 4'h0;
                s_next.rxn  = 3'h0;
              end
            end
          endcase
        end
        ML_RX: begin
          unique case (s_reg.q)
            2'h0: s_next.sda_oe_n = (s_reg.bitn != BITS_BYTE) || (s_reg.rxn == CFG_LAST);
            2'h1: s_next.scl_oe_n = 1'h1;
            2'h2: begin
              if (s_reg.bitn != BITS_BYTE) begin
                s_next.sh_m = {s_reg.sh_m[6:0], pins.sda};
              end
            end
            2'h3: begin
              s_next.scl_oe_n = 1'h0;
              if (s_reg.bitn != BITS_BYTE) begin
                s_next.bitn = 4'(s_reg.bitn + 4'h1);
              end else begin
                if (s_reg.rxn == 3'h0) begin
                  s_next.sig_ok = (s_reg.sh_m == EE_SIGNATURE);
                end else begin
                  s_next.cfg[2'(s_reg.rxn - 3'h1)] = s_reg.sh_m;
                end
                s_next.bitn = 4'h0;
                s_next.rxn  = 3'(s_reg.rxn + 3'h1);
                if (s_reg.rxn == CFG_LAST) begin
                  s_next.ml = ML_STOP;
                end
              end
            end
          endcase
        end
        ML_STOP: begin
          unique case (s_reg.q)
            2'h0: s_next.sda_oe_n = 1'h0;
            2'h1: s_next.scl_oe_n = 1'h1;
            2'h2: s_next.sda_oe_n = 1'h1;
            // done falls only on a passed load
            2'h3: begin
              s_next.ml     = s_reg.sig_ok ? ML_DONE : ML_FAIL;
              s_next.done_n = ~s_reg.sig_ok;
            end
          endcase
        end
        default: s_next.ml = ML_FAIL;
      endcase
    end
    // stall for good with both lines released and done high
    if (s_next.ml == ML_FAIL) begin
      s_next.sda_oe_n = 1'h1;
      s_next.scl_oe_n = 1'h1;
      s_next.done_n   = 1'h1;
    end

    // register slave, sampled clock edges
    if (!s_en) begin
      s_next.sl = SL_IDLE;
      if (s_reg.sl != SL_IDLE) begin
        s_next.sda_oe_n = 1'h1;
      end
    end else if (start_c) begin
      s_next.sl       = SL_ADDR;
      s_next.scnt     = 4'h0;
      s_next.sda_oe_n = 1'h1;
    end else if (stop_c) begin
      s_next.sl       = SL_IDLE;
      s_next.sda_oe_n = 1'h1;
    end else begin
      unique case (s_reg.sl)
        SL_IDLE: s_next.sl = SL_IDLE;
        SL_ADDR, SL_WR: begin
          if (rise) begin
            s_next.sh_s = {s_reg.sh_s[6:0], pins.sda};
            s_next.scnt = 4'(s_reg.scnt + 4'h1);
          end else if (fall && (s_reg.scnt == BITS_BYTE)) begin
            s_next.sda_oe_n = 1'h0;
            if (s_reg.sl == SL_ADDR) begin
              s_next.rw    = s_reg.sh_s[0];
              s_next.first = 1'h1;
              s_next.sl    = (s_reg.sh_s[7:1] == slv_addr[7:1]) ? SL_AACK : SL_IDLE;
              s_next.sda_oe_n = (s_reg.sh_s[7:1] != slv_addr[7:1]);
            end else begin
              // first written byte is the register pointer
              s_next.first = 1'h0;
              s_next.sl    = SL_WACK;
              if (s_reg.first) begin
                s_next.ptr = s_reg.sh_s[1:0];
              end else begin
                s_next.cfg[s_reg.ptr] = s_reg.sh_s;
                s_next.ptr = 2'(s_reg.ptr + 2'h1);
                s_next.status[IRQ_BUS_WR] = 1'h1;
              end
            end
          end
        end
        SL_AACK: begin
          if (fall) begin
            s_next.scnt = 4'h0;
            if (s_reg.rw) begin
              s_next.sl       = SL_RD;
              s_next.sh_s     = s_reg.cfg[s_reg.ptr];
              s_next.sda_oe_n = s_reg.cfg[s_reg.ptr][7];
            end else begin
              s_next.sl       = SL_WR;
              s_next.sda_oe_n = 1'h1;
            end
          end
        end
        SL_WACK: begin
          if (fall) begin
            s_next.sl       = SL_WR;
            s_next.scnt     = 4'h0;
            s_next.sda_oe_n = 1'h1;
          end
        end
        SL_RD: begin
          if (rise) begin
            s_next.scnt = 4'(s_reg.scnt + 4'h1);
          end else if (fall) begin
            if (s_reg.scnt == BITS_BYTE) begin
              s_next.sda_oe_n = 1'h1;
              s_next.sl       = SL_RACK;
            end else begin
              s_next.sh_s     = {s_reg.sh_s[6:0], 1'h0};
              s_next.sda_oe_n = s_reg.sh_s[6];
            end
          end
        end
        SL_RACK: begin
          if (rise) begin
            s_next.nack = pins.sda;
            if (!pins.sda) begin
              s_next.ptr = 2'(s_reg.ptr + 2'h1);
            end
          end else if (fall) begin
            s_next.scnt = 4'h0;
            if (s_reg.nack) begin
              s_next.sl = SL_IDLE;
            end else begin
              s_next.sl       = SL_RD;
              s_next.sh_s     = s_reg.cfg[s_reg.ptr];
              s_next.sda_oe_n = s_reg.cfg[s_reg.ptr][7];
            end
          end
        end
      endcase
    end

    // equalization from straps only in pin mode
    // de-emphasis from straps only in pin mode
    if (s_reg.mode == MODE_PIN) begin
      s_next.eq_a  = {pins.ad[1], pins.ad[0]};
      s_next.eq_b  = {pins.ad[2], pins.ad[3]};
      s_next.dem_a = pins.dem_a;
      s_next.dem_b = pins.dem_b;
      s_next.signal_detect_threshold = pins.load_lvl;
    end else begin
      s_next.eq_a  = s_reg.cfg[CFG_EQA][3:0];
      s_next.eq_b  = s_reg.cfg[CFG_EQB][3:0];
      s_next.dem_a = s_reg.cfg[CFG_DEM][CHAN_A_DEEMPH_STRAP_LSB +: 2];
      s_next.dem_b = s_reg.cfg[CFG_DEM][CHAN_B_DEEMPH_STRAP_LSB +: 2];
      // threshold stays at its default in bus modes
      s_next.signal_detect_threshold = LVL_FLOAT;
    end

    // low power while the cable is absent
    s_next.low_power = pins.cable_absent;
    s_next.cable_d   = pins.cable_absent;
    unique case (pins.rate)
      LVL_GND_STRONG: s_next.rate = RATE_G12;
      LVL_FLOAT:      s_next.rate = RATE_AUTO;
      LVL_GND_WEAK:   s_next.rate = RATE_G3;
      LVL_VDD:        s_next.rate = RATE_RSVD;
    endcase
    // follow the detected rate inside what the rate mode allows
    unique case (s_reg.rate)
      RATE_G12:  s_next.gen = (pins.gen_det == GEN3) ? GEN2 : pins.gen_det;
      RATE_G3:   s_next.gen = GEN3;
      RATE_AUTO, RATE_RSVD: s_next.gen = pins.gen_det;
    endcase
    s_next.term_low = (pins.receiver_termination_select != LVL_GND_STRONG);

    // events set after any read clear so a same-cycle event survives
    if ((s_reg.ml == ML_STOP) && (s_next.ml == ML_DONE)) begin
      s_next.status[IRQ_LOAD_OK] = 1'h1;
    end
    if ((s_reg.ml != ML_FAIL) && (s_next.ml == ML_FAIL)) begin
      s_next.status[IRQ_LOAD_FAIL] = 1'h1;
    end
    if (s_reg.cable_d != pins.cable_absent) begin
      s_next.status[IRQ_CABLE] = 1'h1;
    end
    if (s_next.mode != s_reg.mode) begin
      s_next.status[IRQ_MODE] = 1'h1;
    end
    s_next.irq = |(s_next.status & s_next.mask);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg          <= '0;
      s_reg.mask     <= MASK_RST;
      s_reg.cfg      <= CFG_RST;
      s_reg.sda_oe_n <= 1'h1;
      s_reg.scl_oe_n <= 1'h1;
      s_reg.done_n   <= 1'h1;
      s_reg.signal_detect_threshold    <= LVL_FLOAT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_wb_dat                  = s_reg.wb_dat;
  assign o_wb_ack                  = s_reg.wb_ack;
  assign o_irq                     = s_reg.irq;
  assign o_sda                     = s_reg.od_lvl;
  assign o_sda_oe_n                = s_reg.sda_oe_n;
  assign o_scl                     = s_reg.od_lvl;
  assign o_scl_oe_n                = s_reg.scl_oe_n;
  assign o_done_n                  = s_reg.done_n;
  assign o_chan_a_equalize         = s_reg.eq_a;
  assign o_chan_b_equalize         = s_reg.eq_b;
  assign o_chan_a_deemph           = s_reg.dem_a;
  assign o_chan_b_deemph           = s_reg.dem_b;
  assign o_low_power               = s_reg.low_power;
  assign o_rate_mode               = s_reg.rate;
  assign o_term_low_ohm            = s_reg.term_low;
  assign o_link_gen                = s_reg.gen;
  assign o_signal_detect_threshold = s_reg.signal_detect_threshold;
  assign o_mode                    = s_reg.mode;

endmodule : rcl_top

// File: tb/rcl_monitor.sv
`timescale 1ns/1ps
module rcl_mon (
  input wire logic       i_mclk, i_rst_n, i_wb_cyc, i_wb_stb, o_wb_ack, o_done_n,
  input wire logic       i_cable_absent, o_low_power, o_scl_oe_n, o_term_low_ohm,
  input wire logic [7:0] i_slave_addr_straps,
  input wire logic [3:0] o_chan_a_equalize, o_chan_b_equalize,
  input wire logic [1:0] o_mode, i_receiver_termination_select
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
  // eight quiet cycles also skip the reset and pin-sync latency
  sequence s_pin_calm; (o_mode == 2'h0 && $stable(i_slave_addr_straps)) [*8]; endsequence
  a_ack_follows: assert property (s_req |=> o_wb_ack) else $error("ack late");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack long");
  a_done_master: assert property (!o_done_n |-> o_mode == 2'h2) else $error("done mode");
  a_done_holds: assert property (!o_done_n |=> !o_done_n) else $error("done lost");
  a_scl_freed: assert property (!o_done_n |-> o_scl_oe_n) else $error("scl held");
  a_pin_equalize: assert property (s_pin_calm |->
    o_chan_a_equalize == i_slave_addr_straps[3:0] &&
    o_chan_b_equalize == {i_slave_addr_straps[5:4], i_slave_addr_straps[7:6]}) else $error("eq");
  a_low_power: assert property ($rose(i_cable_absent) |-> ##[2:4] o_low_power) else $error("lp");
  a_term_select: assert property ($stable(i_receiver_termination_select) [*8] |->
    o_term_low_ohm == (i_receiver_termination_select != 2'h0)) else $error("term");
endmodule : rcl_mon

bind rcl_top rcl_mon i_mon (.*);

// File: tb/rcl_eeprom.sv
`timescale 1ns/1ps
module rcl_eeprom (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_blank,
  output logic      o_sda_oe_n = 1'b1
);
  logic [4:0][7:0] img;
  logic            rd = 1'b0;
  int              n = 0;
  int              k;
  // a blank part reads all ones, so the signature must fail
  assign img = i_blank ? 40'hFF_FFFF_FFFF : 40'h00_0B06_095A;
  // the scl fall right after a start brings the count to zero
  always @(negedge i_sda) if (i_scl) n = -1;
  always @(posedge i_scl) if (n == 7) rd = i_sda;
  always @(negedge i_scl) begin
    n = n + 1;
    k = (n - 9) % 9;
    if (!rd || n < 9) o_sda_oe_n = (n % 9 != 8);
    else o_sda_oe_n = (k == 8 || n > 53) | img[(n - 9) / 9][7 - k];
  end
endmodule : rcl_eeprom

// File: tb/rcl_top_tb.sv
`timescale 1ns/1ps
module rcl_top_tb
  import rcl_pkg::*;
;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic i_cable_absent = 1'b0, blank = 1'b0;
  logic [7:0] i_wb_adr = '0, i_slave_addr_straps = '0;
  logic [3:0] i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = '0, rd;
  logic [1:0] i_bus_config_select = '0, i_chan_a_deemph_strap = '0, i_chan_b_deemph_strap = '0;
  logic [1:0] i_load_start_n = '0, i_receiver_termination_select = '0, i_rate_select = '0;
  logic [1:0] i_link_gen_detect = 2'h3;
  logic host_sda = 1'h1, host_scl = 1'h1;
  logic [1:0] rate_exp [4] = '{RATE_G12, RATE_G3, RATE_AUTO, RATE_RSVD};
  wire i_sda, i_scl, ee_oe_n, o_sda, o_scl, o_sda_oe_n, o_scl_oe_n, o_wb_ack, o_irq;
  wire o_done_n, o_low_power, o_term_low_ohm;
  wire [31:0] o_wb_dat;
  wire [3:0] o_chan_a_equalize, o_chan_b_equalize;
  wire [1:0] o_chan_a_deemph, o_chan_b_deemph, o_rate_mode, o_link_gen, o_mode;
  wire [1:0] o_signal_detect_threshold;
  int fail_count = 0, check_count = 0;
  // both open-drain lines have pull-ups
  assign i_sda = o_sda_oe_n & ee_oe_n & host_sda;
  assign i_scl = o_scl_oe_n & host_scl;
  always #10 i_mclk = ~i_mclk;
  rcl_top i_rcl_top (.*);
  rcl_eeprom i_rcl_eeprom (.i_scl(i_scl), .i_sda(i_sda), .i_blank(blank), .o_sda_oe_n(ee_oe_n));

  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n = 0;
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= dat;
    // the wait ends when ack is seen; the watchdog ends it only if ack never comes
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_wb_ack !== 1'b1);
    // ack is seen at the second edge after the request
    chk(n, 32'h2);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask : wb

  // one serial bit from the host: data first, then an 80 ns clock pulse
  task automatic sbit(input logic b);
    host_sda <= b;
    repeat (4) @(posedge i_mclk);
    host_scl <= 1'h1;
    repeat (4) @(posedge i_mclk);
    host_scl <= 1'h0;
  endtask : sbit

  // the closing status read drops the mode event raised at reset
  task automatic rst(input logic [1:0] sel, input logic [1:0] ld, input logic blk);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    i_bus_config_select <= sel;
    i_load_start_n <= ld;
    blank <= blk;
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
    wb(1'b0, 8'h00, '0);
  endtask : rst

  task automatic t_pin();
    rst(2'h0, 2'h3, 1'b0);
    i_slave_addr_straps <= 8'h1B;
    i_chan_a_deemph_strap <= 2'h1;
    i_chan_b_deemph_strap <= 2'h2;
    repeat (5) @(posedge i_mclk);
    chk({o_chan_a_equalize, o_chan_b_equalize}, 8'hB4);
    chk({o_chan_a_deemph, o_chan_b_deemph, o_mode, o_done_n}, 7'h31);
    for (int i = 0; i < 4; i++) begin
      i_rate_select <= 2'(i);
      i_receiver_termination_select <= 2'(i);
      i_load_start_n <= 2'(i);
      repeat (5) @(posedge i_mclk);
      chk({o_rate_mode, o_term_low_ohm, o_signal_detect_threshold, o_link_gen},
        {rate_exp[i], i != 0, 2'(i), ((i == 0) ? GEN2 : GEN3)});
    end
    wb(1'b1, 8'h04, 32'h4);
    i_cable_absent <= 1'b1;
    repeat (6) @(posedge i_mclk);
    chk({o_low_power, o_irq}, 2'h3);
    wb(1'b0, 8'h00, '0);
    chk(rd, 32'h4);
    wb(1'b1, 8'h04, '0);
    i_cable_absent <= 1'b0;
    repeat (6) @(posedge i_mclk);
    chk({o_low_power, o_irq}, 2'h0);
    wb(1'b0, 8'h00, '0);
    chk(rd, 32'h4);
    wb(1'b1, 8'h0C, 32'hA5C3_0F07);
    wb(1'b0, 8'h0C, '0);
    chk(rd, 32'hA5C3_0F07);
    wb(1'b0, 8'h40, '0);
    chk(rd, 32'h0);
  endtask : t_pin

  task automatic t_slave();
    logic [26:0] frm = {8'hB4, 1'h1, 8'h01, 1'h1, 8'h3C, 1'h1};
    i_slave_addr_straps <= 8'h8C;
    rst(2'h3, 2'h0, 1'b0);
    wb(1'b0, 8'h04, '0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h08, '0);
    chk({rd[23:16], rd[2:0], o_chan_a_equalize}, 15'h5A50);
    // host writes 3C to cfg byte 1 through pointer 1, then stops
    host_sda <= 1'h0;
    repeat (4) @(posedge i_mclk);
    host_scl <= 1'h0;
    for (int i = 26; i >= 0; i--) sbit(frm[i]);
    host_sda <= 1'h0;
    repeat (4) @(posedge i_mclk);
    host_scl <= 1'h1;
    repeat (4) @(posedge i_mclk);
    host_sda <= 1'h1;
    repeat (6) @(posedge i_mclk);
    wb(1'b0, 8'h0C, '0);
    chk(rd, 32'h0000_3C00);
    chk(o_chan_b_equalize, 4'hC);
    wb(1'b0, 8'h00, '0);
    chk(rd, 32'h8);
    i_load_start_n <= 2'h2;
    repeat (5) @(posedge i_mclk);
    wb(1'b0, 8'h08, '0);
    chk(rd[23:16], 8'hB0);
  endtask : t_slave

  task automatic t_master(input logic blk);
    // load pin held low from power-up requests the fetch
    rst(2'h2, 2'h0, blk);
    for (int t = 0; t < 40000 && o_done_n !== 1'b0; t++) @(posedge i_mclk);
    wb(1'b0, 8'h08, '0);
    chk({o_done_n, rd[3]}, {blk, blk});
    i_load_start_n <= 2'h3;
    repeat (5) @(posedge i_mclk);
    if (!blk) chk({o_chan_a_equalize, o_chan_b_equalize, o_chan_a_deemph, o_chan_b_deemph,
      o_signal_detect_threshold}, {12'h96E, LVL_FLOAT});
  endtask : t_master

  initial begin
    t_pin();
    t_slave();
    t_master(1'b0);
    t_master(1'b1);
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge i_mclk);
    fail_count++;
    stop_test();
  end
endmodule : rcl_top_tb
